//--- rtl/nfbo_ctrl.v
// host side controller for a page-mode nor flash parallel bus
// Summary of operation
// - array read drives select and output enable low, write enable high, valid address.
// - a command write drives write enable and select low, output enable high.
// - high voltage is applied only while accelerated programming.
`timescale 1ns/1ns
`default_nettype none
`include "nfbo_regs.vh"
module nfbo_ctrl #(
   parameter AW = `NFBO_ADDR_W,
   parameter DW = `NFBO_DATA_W
) (
   input wire ref_clk_i, // clock, 250 MHz
   input wire rst_i, // sync reset, high
   input wire req_i, // start a bus operation
   input wire [1:0] cmd_i, // read, write or reset
   input wire [AW-1:0] addr_i, // word address
   input wire [DW-1:0] wdata_i, // write data
   input wire accel_i, // request accelerated programming
   input wire protect_i, // hold boot sector group protected
   output reg busy_o, // operation in progress
   output reg done_o, // one-cycle completion pulse
   output reg [DW-1:0] rdata_o, // read data
   output reg [AW-1:0] flash_addr_o, // address pins
   input wire [DW-1:0] data_lines_i, // data pins in
   output reg [DW-1:0] data_lines_o, // data pins out
   output reg data_lines_oe_o, // host drives data pins
   output reg flash_ce_n_o, // chip select, low
   output reg flash_oe_n_o, // output enable, low
   output reg flash_we_n_o, // write enable, low
   output reg flash_reset_n_o, // device reset, low
   output reg protect_accel_pin_o, // protect level, high when free
   output reg accel_high_voltage_o // switch high voltage onto protect pin
);
   localparam TW = 8;
   // round a delay up to whole clock cycles, so no phase ends early on the pins
   function [TW-1:0] ns_to_cyc;
      input integer ns;
      integer c;
      begin
         c = (ns + `NFBO_CLK_NS - 1) / `NFBO_CLK_NS;
         ns_to_cyc = c[TW-1:0];
      end
   endfunction
   localparam [TW-1:0] ACC_CYC = ns_to_cyc(`NFBO_RANDOM_ACCESS_TIME_NS);
   localparam [TW-1:0] PACC_CYC = ns_to_cyc(`NFBO_PAGE_ACCESS_TIME_NS);
   localparam [TW-1:0] WP_CYC = ns_to_cyc(`NFBO_T_WP_NS);
   localparam [TW-1:0] WPH_CYC = ns_to_cyc(`NFBO_T_WPH_NS);
   localparam [TW-1:0] RP_CYC = ns_to_cyc(`NFBO_T_RP_NS);
   localparam [TW-1:0] RH_CYC = ns_to_cyc(`NFBO_T_RH_NS);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_READ = 6'h02;
   localparam [5:0] S_WR = 6'h04;
   localparam [5:0] S_WRH = 6'h08;
   localparam [5:0] S_RST = 6'h10;
   localparam [5:0] S_RSTH = 6'h20;
   reg [5:0] state;
   reg [AW-`NFBO_PAGE_BITS-1:0] open_page;
   reg page_open;
   reg load;
   reg [TW-1:0] load_cnt;
   wire tdone;
   wire same_page;
   // page number of a word address: all bits above the in-page word select
   function [AW-`NFBO_PAGE_BITS-1:0] page_of;
      input [AW-1:0] a;
      begin
         page_of = a[AW-1:`NFBO_PAGE_BITS];
      end
   endfunction
   assign same_page = page_open && (page_of(addr_i) == open_page);
   // one shared timer; bus phases never overlap
   nfbo_timer #(.W(TW)) u_timer (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .load_i(load),
      .count_i(load_cnt),
      .done_o(tdone)
   );
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= {DW{1'b0}};
         flash_addr_o <= {AW{1'b0}};
         data_lines_o <= {DW{1'b0}};
         data_lines_oe_o <= 1'b0;
         flash_ce_n_o <= 1'b1;
         flash_oe_n_o <= 1'b1;
         flash_we_n_o <= 1'b1;
         flash_reset_n_o <= 1'b1;
         protect_accel_pin_o <= 1'b1;
         accel_high_voltage_o <= 1'b0;
         open_page <= {(AW-`NFBO_PAGE_BITS){1'b0}};
         page_open <= 1'b0;
         load <= 1'b0;
         load_cnt <= {TW{1'b0}};
      end else begin
         load <= 1'b0;
         done_o <= 1'b0;
         // high voltage only while a write runs in accelerated mode
         accel_high_voltage_o <= accel_i && (state == S_WR || state == S_WRH);
         protect_accel_pin_o <= ~protect_i;
         // !load skips the stale done of the timer in the first cycle of a phase
         case (state)
            S_IDLE: begin
               busy_o <= 1'b0;
               if (req_i) begin
                  busy_o <= 1'b1;
                  flash_addr_o <= addr_i;
                  load <= 1'b1;
                  if (cmd_i == `NFBO_CMD_READ) begin
                     // reads need no command; chip select stays low between reads
                     flash_ce_n_o <= 1'b0;
                     flash_oe_n_o <= 1'b0;
                     flash_we_n_o <= 1'b1;
                     data_lines_oe_o <= 1'b0;
                     load_cnt <= same_page ? PACC_CYC : ACC_CYC;
                     open_page <= page_of(addr_i);
                     page_open <= 1'b1;
                     state <= S_READ;
                  end else if (cmd_i == `NFBO_CMD_WRITE) begin
                     // every command word is one bus write cycle
                     flash_ce_n_o <= 1'b0;
                     flash_oe_n_o <= 1'b1;
                     flash_we_n_o <= 1'b0;
                     data_lines_o <= wdata_i;
                     data_lines_oe_o <= 1'b1;
                     // raised with the data drivers, so never outside a write
                     accel_high_voltage_o <= accel_i;
                     load_cnt <= WP_CYC;
                     page_open <= 1'b0;
                     state <= S_WR;
                  end else begin
                     // codes 2 and 3 both pulse the reset pin
                     flash_ce_n_o <= 1'b1;
                     flash_oe_n_o <= 1'b1;
                     flash_we_n_o <= 1'b1;
                     data_lines_oe_o <= 1'b0;
                     flash_reset_n_o <= 1'b0;
                     load_cnt <= RP_CYC;
                     page_open <= 1'b0;
                     state <= S_RST;
                  end
               end
            end
            S_READ: begin
               if (tdone && !load) begin
                  // sampled on the last wait edge; oe released on that same edge
                  rdata_o <= data_lines_i;
                  flash_oe_n_o <= 1'b1;
                  done_o <= 1'b1;
                  busy_o <= 1'b0;
                  state <= S_IDLE;
               end
            end
            S_WR: begin
               // write pulse width first, then hold time before the next cycle
               if (tdone && !load) begin
                  flash_we_n_o <= 1'b1;
                  load <= 1'b1;
                  load_cnt <= WPH_CYC;
                  state <= S_WRH;
               end
            end
            S_WRH: begin
               if (tdone && !load) begin
                  // deselect is safe: an embedded operation keeps running
                  flash_ce_n_o <= 1'b1;
                  data_lines_oe_o <= 1'b0;
                  accel_high_voltage_o <= 1'b0;
                  done_o <= 1'b1;
                  busy_o <= 1'b0;
                  state <= S_IDLE;
               end
            end
            S_RST: begin
               // device ignores the bus for the whole pulse
               if (tdone && !load) begin
                  flash_reset_n_o <= 1'b1;
                  load <= 1'b1;
                  load_cnt <= RH_CYC;
                  state <= S_RSTH;
               end
            end
            S_RSTH: begin
               // recovery time before the first access after reset
               if (tdone && !load) begin
                  done_o <= 1'b1;
                  busy_o <= 1'b0;
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // nfbo_ctrl
`default_nettype wire

//--- rtl/nfbo_regs.vh
// constants for the nor flash bus controller
`ifndef NFBO_REGS_VH
`define NFBO_REGS_VH
`define NFBO_ADDR_W 24
`define NFBO_DATA_W 16
`define NFBO_PAGE_BITS 3
`define NFBO_SECTOR_LSB 16
`define NFBO_BUF_WORDS 16
`define NFBO_RANDOM_ACCESS_TIME_NS 110
`define NFBO_PAGE_ACCESS_TIME_NS 30
`define NFBO_T_WP_NS 35
`define NFBO_T_WPH_NS 30
`define NFBO_T_RP_NS 500
`define NFBO_T_RH_NS 50
`define NFBO_CLK_NS 4
`define NFBO_CMD_READ 2'h0
`define NFBO_CMD_WRITE 2'h1
`define NFBO_CMD_RESET 2'h2
`endif

//--- rtl/nfbo_timer.v
// down counter that times one bus phase
`timescale 1ns/1ns
`default_nettype none
module nfbo_timer #(
   parameter W = 8
) (
   input wire ref_clk_i, // clock
   input wire rst_i, // sync reset, high
   input wire load_i, // start a phase
   input wire [W-1:0] count_i, // cycles in the phase
   output reg done_o // high when phase over
);
   reg [W-1:0] cnt;
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt <= {W{1'b0}};
         done_o <= 1'b1;
      end else if (load_i) begin
         cnt <= count_i;
         done_o <= 1'b0;
      end else if (cnt > {{(W-1){1'b0}}, 1'b1}) begin
         cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end else begin
         cnt <= {W{1'b0}};
         done_o <= 1'b1;
      end
   end
endmodule // nfbo_timer
`default_nettype wire

//--- tb/nfbo_ctrl_properties.sv
// pin-level assertions for the nor flash bus controller
`timescale 1ns/1ns
`default_nettype none
module nfbo_ctrl_properties (
   input wire logic ref_clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic accel_i, // accel request
   input wire logic data_lines_oe_o, // host drives data
   input wire logic flash_ce_n_o, // select
   input wire logic flash_oe_n_o, // output enable
   input wire logic flash_we_n_o, // write enable
   input wire logic flash_reset_n_o, // device reset
   input wire logic accel_high_voltage_o // high voltage switch
);
   logic [7:0] low_cnt;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // saturates so a long pulse cannot wrap back under the minimum
   always @(posedge ref_clk_i) begin
      if (rst_i || flash_reset_n_o) low_cnt <= 8'h00;
      else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
   end
   read_levels_a: assert property (!flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o) else $error("bad read");
   write_levels_a: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && data_lines_oe_o)
      else $error("bad write");
   no_fight_a: assert property (data_lines_oe_o |-> flash_oe_n_o) else $error("bus contention");
   hv_write_only_a: assert property (accel_high_voltage_o |-> $past(accel_i) && data_lines_oe_o) else $error("stray hv");
   page_wait_a: assert property ($fell(flash_oe_n_o) |=> !flash_oe_n_o [*7]) else $error("short read");
   we_width_a: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*8] ##1 !flash_we_n_o) else $error("short we");
   reset_width_a: assert property ($rose(flash_reset_n_o) |-> low_cnt >= 8'h7D) else $error("short reset");
   reset_quiet_a: assert property (!flash_reset_n_o |-> flash_ce_n_o && flash_we_n_o) else $error("busy in reset");
endmodule // nfbo_ctrl_properties
`default_nettype wire

//--- tb/nfbo_flash_model.sv
// behavioural nor flash device: timed array reads, word writes
`timescale 1ns/1ns
`default_nettype none
module nfbo_flash_model (
   input wire logic clk_i, // sampling clock
   input wire logic [23:0] addr_i, // address pins
   input wire logic [15:0] dq_i, // resolved data bus
   input wire logic ce_n_i, // select
   input wire logic oe_n_i, // output enable
   input wire logic we_n_i, // write enable
   input wire logic reset_n_i, // reset
   output logic [15:0] dq_o // data to host
);
   logic [15:0] mem [0:255];
   logic [15:0] junk = 16'hA5C3;
   logic [23:0] a_q = 24'h000000;
   logic [7:0] age = 8'h00;
   logic open_q = 1'b0, full_q = 1'b1, we_q = 1'b1;
   wire act = !ce_n_i && reset_n_i;
   wire ok = age >= (full_q ? 8'h1B : 8'h07);
   initial for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
   // only array reads exist here; an undriven bus toggles, never holds
   assign dq_o = (act && !oe_n_i && we_n_i && ok) ? mem[addr_i[7:0]] : junk;
   always @(posedge clk_i) begin
      junk <= ~junk;
      we_q <= we_n_i;
      open_q <= act;
      a_q <= addr_i;
      if (!act) age <= 8'h00;
      else if (!open_q || addr_i != a_q) begin
         age <= 8'h01;
         full_q <= !open_q || addr_i[23:3] != a_q[23:3];
      end else if (age != 8'hFF) age <= age + 8'h01;
      if (act && !we_q && we_n_i) mem[addr_i[7:0]] <= mem[addr_i[7:0]] & dq_i;
   end
endmodule // nfbo_flash_model
`default_nettype wire

//--- tb/nor_flash_bus_operations_tb_top.sv
// self-checking bench for the nor flash bus controller
`timescale 1ns/1ns
`default_nettype none
`include "nfbo_regs.vh"
module nor_flash_bus_operations_tb_top;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, accel_i = 1'b0, protect_i = 1'b0, hv = 1'b0;
   logic [1:0] cmd_i = 2'h0;
   logic [23:0] addr_i = 24'h000000;
   logic [15:0] wdata_i = 16'h0000, rd;
   int n_mismatch = 0, compares = 0, n;
   wire busy_o, done_o, data_lines_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o;
   wire protect_accel_pin_o, accel_high_voltage_o;
   wire [15:0] rdata_o, data_lines_o, dq;
   wire [23:0] flash_addr_o;
   wire [15:0] data_lines_i = data_lines_oe_o ? data_lines_o : dq;
   always #2 ref_clk_i = ~ref_clk_i;
   nfbo_ctrl dut_u (.ref_clk_i, .rst_i, .req_i, .cmd_i, .addr_i, .wdata_i, .accel_i, .protect_i, .busy_o, .done_o,
      .rdata_o, .flash_addr_o, .data_lines_i, .data_lines_o, .data_lines_oe_o, .flash_ce_n_o, .flash_oe_n_o,
      .flash_we_n_o, .flash_reset_n_o, .protect_accel_pin_o, .accel_high_voltage_o);
   nfbo_flash_model mem_u (.clk_i(ref_clk_i), .addr_i(flash_addr_o), .dq_i(data_lines_i), .ce_n_i(flash_ce_n_o),
      .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .reset_n_i(flash_reset_n_o), .dq_o(dq));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one request, then wait on done; n counts cycles for timing checks
   task automatic op(input logic [1:0] c, input logic [23:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      req_i <= 1'b1;
      cmd_i <= c;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      req_i <= 1'b0;
      n = 0;
      while (done_o !== 1'b1) begin
         @(negedge ref_clk_i);
         hv = hv | accel_high_voltage_o;
         n++;
         if (n == 1) chk("busy", 16'h0001, busy_o);
         if (n > 400) begin
            n_mismatch++;
            $display("CHECK FAILED done expected 1 seen 0");
            complete_run();
         end
      end
      rd = rdata_o;
      chk("idle", 16'h0000, busy_o);
   endtask
   task automatic s_page();
      chk("protect idle", 16'h0001, protect_accel_pin_o);
      op(`NFBO_CMD_READ, 24'h000010, 16'h0000);
      chk("boot word", 16'hFFFF, rd);
      chk("boot access", 16'h0001, n >= 28);
      op(`NFBO_CMD_WRITE, 24'h000021, 16'h1234);
      chk("standby ce", 16'h0001, flash_ce_n_o);
      chk("bus released", 16'h0000, data_lines_oe_o);
      op(`NFBO_CMD_WRITE, 24'h000022, 16'h5678);
      op(`NFBO_CMD_READ, 24'h000021, 16'h0000);
      chk("written word", 16'h1234, rd);
      op(`NFBO_CMD_READ, 24'h000022, 16'h0000);
      chk("page word", 16'h5678, rd);
      chk("page access", 16'h0001, n < 20);
      chk("addr pins", 16'h0022, flash_addr_o[15:0]);
      chk("ce held", 16'h0000, flash_ce_n_o);
      chk("oe released", 16'h0001, flash_oe_n_o);
      op(`NFBO_CMD_READ, 24'h000028, 16'h0000);
      chk("new page access", 16'h0001, n >= 28);
   endtask
   task automatic s_accel();
      @(posedge ref_clk_i);
      accel_i <= 1'b1;
      op(`NFBO_CMD_WRITE, 24'h000030, 16'h00FF);
      chk("hv on", 16'h0001, hv);
      @(posedge ref_clk_i);
      accel_i <= 1'b0;
      hv = 1'b0;
      op(`NFBO_CMD_WRITE, 24'h000031, 16'h0F0F);
      chk("hv off", 16'h0000, hv);
      op(`NFBO_CMD_READ, 24'h000030, 16'h0000);
      chk("accel word", 16'h00FF, rd);
   endtask
   task automatic s_reset();
      @(posedge ref_clk_i);
      protect_i <= 1'b1;
      op(`NFBO_CMD_RESET, 24'h000000, 16'h0000);
      chk("protect pin", 16'h0000, protect_accel_pin_o);
      op(2'h3, 24'h000000, 16'h0000);
      chk("reset pin", 16'h0001, flash_reset_n_o);
      op(`NFBO_CMD_READ, 24'h000021, 16'h0000);
      chk("word after reset", 16'h1234, rd);
      chk("reset access", 16'h0001, n >= 28);
   endtask
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      s_page();
      s_accel();
      s_reset();
      complete_run();
   end
endmodule // nor_flash_bus_operations_tb_top
bind nfbo_ctrl nfbo_ctrl_properties chk_u (.ref_clk_i, .rst_i, .accel_i, .data_lines_oe_o, .flash_ce_n_o,
   .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o, .accel_high_voltage_o);
`default_nettype wire
